// File: hw/power_seq_defs.vh
// Purpose: Constants for the battery mode power sequencer.
// Assumes: One 10 MHz clock, slow tick arrives as a slow clock whose rising edge is used.
// Notes: The SFR offset, supply codes and tick counts live here; mode codes and synchroniser bits stay in the module.
`ifndef POWER_SEQ_DEFS_VH
`define POWER_SEQ_DEFS_VH
`define SUPPLY_STATE_ADDR     8'hF9
`define CODE_POWER_GOOD       3'h0
`define CODE_POWER_LOW        3'h1
`define CODE_BATT_CORE_GOOD   3'h2
`define CODE_BATT_CORE_MARGIN 3'h3
`define CODE_BATT_CORE_FAIL   3'h5
`define BOOST_SELECT_ON       2'h2
`define FAIL_RESET_TICKS      3'h4
`define BLINK_HALF_TICKS      16'h4000
`endif

// File: hw/battery_mode_power_sequencer.v
// Purpose: Mode controller for mission and three battery modes.
// Assumes: Comparators, wake pins and slow tick are asynchronous; rest on sys_clk_in.
// Notes: Supply code read over a simple SFR read port.
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defs.vh"
module battery_mode_power_sequencer (
  input  wire       sys_clk_in,
  input  wire       reset_in,
  input  wire       sys_above_hi_in,
  input  wire       sys_above_lo_in,
  input  wire       core_above_mid_in,
  input  wire       core_above_min_in,
  input  wire       wake_timer_in,
  input  wire       pushbutton_in,
  input  wire       seg_wake_in,
  input  wire       serial_rx_in,
  input  wire       slow_tick_clock_in,
  input  wire       sleep_set_in,
  input  wire       display_only_request_in,
  input  wire [1:0] display_boost_select_in,
  input  wire [7:0] sfr_addr_in,
  input  wire       sfr_rd_in,
  input  wire       blink_enable_a_in,
  input  wire       blink_enable_b_in,
  input  wire       segment_a_data_in,
  input  wire       segment_b_data_in,
  input  wire       segment_drive_in,
  output reg  [7:0] sfr_rdata_out,
  output reg  [3:0] mode_out,
  output reg        on_battery_out,
  output reg        battery_irq_out,
  output reg        pll_enable_out,
  output reg        digital_supply_rail_out,
  output reg        segment_drive_out,
  output reg        blink_segment_pin_a_out,
  output reg        blink_segment_pin_b_out,
  output reg        processor_reset_out,
  output reg        wake_out,
  output reg        config_reset_out,
  output reg        flash_write_block_out,
  output reg        converter_clock_enable_out,
  output reg        low_core_supply_wake_flag_out
);
  localparam [3:0] ST_MISSION  = 4'b0001;
  localparam [3:0] ST_BROWNOUT = 4'b0010;
  localparam [3:0] ST_DISPLAY  = 4'b0100;
  localparam [3:0] ST_SLEEP    = 4'b1000;

  // Synchroniser bit positions
  localparam integer SYNC_SYS_HI   = 0;
  localparam integer SYNC_SYS_LO   = 1;
  localparam integer SYNC_CORE_MID = 2;
  localparam integer SYNC_CORE_MIN = 3;
  localparam integer SYNC_TIMER    = 4;
  localparam integer SYNC_BUTTON   = 5;
  localparam integer SYNC_SEG      = 6;
  localparam integer SYNC_RX       = 7;
  localparam integer SYNC_TICK     = 8;
  // Comparators idle high: no false battery switch after reset
  localparam [8:0]   SYNC_IDLE     = 9'h00F;

  // Sleep and display-only both leave the processor dormant
  function is_dormant;
    input [3:0] st;
    begin
      is_dormant = st == ST_SLEEP || st == ST_DISPLAY;
    end
  endfunction

  // Blank a blink pin during the off half of the period
  function blink_level;
    input data;
    input enable;
    input in_disp;
    input phase;
    begin
      blink_level = data & ~(in_disp & enable & phase);
    end
  endfunction

  reg [8:0] sync1_reg;
  reg [8:0] sync2_reg;
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
    end else begin
      sync1_reg <= {slow_tick_clock_in, serial_rx_in, seg_wake_in,
                    pushbutton_in, wake_timer_in, core_above_min_in,
                    core_above_mid_in, sys_above_lo_in, sys_above_hi_in};
      sync2_reg <= sync1_reg;
    end
  end
  wire sys_hi      = sync2_reg[SYNC_SYS_HI];
  wire sys_lo      = sync2_reg[SYNC_SYS_LO];
  wire core_mid    = sync2_reg[SYNC_CORE_MID];
  wire core_min    = sync2_reg[SYNC_CORE_MIN];
  wire timer_wake  = sync2_reg[SYNC_TIMER];
  wire button_wake = sync2_reg[SYNC_BUTTON];
  wire seg_level   = sync2_reg[SYNC_SEG];
  wire rx_level    = sync2_reg[SYNC_RX];
  wire tick        = sync2_reg[SYNC_TICK];

  reg [8:4] prev_reg;
  reg       tick_q_reg;
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      prev_reg <= 5'h00;
      tick_q_reg <= 1'b0;
    end else begin
      prev_reg <= sync2_reg[8:4];
      tick_q_reg <= tick;
    end
  end
  wire tick_rise = tick & ~tick_q_reg;
  wire seg_rise  = seg_level & ~prev_reg[SYNC_SEG];
  wire rx_edge   = rx_level ^ prev_reg[SYNC_RX];
  // timer, button, segment rise, serial activity
  wire wake_event = timer_wake | button_wake | seg_rise | rx_edge;

  reg [2:0] code_next;
  always @* begin
    if (sys_hi)
      code_next = `CODE_POWER_GOOD;
    else if (sys_lo)
      code_next = `CODE_POWER_LOW;
    else if (core_mid)
      code_next = `CODE_BATT_CORE_GOOD;
    else if (core_min)
      code_next = `CODE_BATT_CORE_MARGIN;
    else
      code_next = `CODE_BATT_CORE_FAIL;
  end

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [2:0] code_reg;
  reg [2:0] fail_cnt_reg;
  reg       hold_reg;
  reg       bad_seen_reg;
  reg       rewake_reg;
  reg [15:0] blink_cnt_reg;
  reg        blink_phase_reg;

  wire power_present = sys_lo;
  wire fail_reset = fail_cnt_reg == `FAIL_RESET_TICKS;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_MISSION: begin
        if (display_only_request_in)
          state_next = ST_DISPLAY;
        else if (sleep_set_in)
          state_next = ST_SLEEP;
        else if (!power_present)
          state_next = ST_BROWNOUT;
      end
      ST_BROWNOUT: begin
        if (power_present)
          state_next = ST_MISSION;
        else if (display_only_request_in)
          state_next = ST_DISPLAY;
        else if (sleep_set_in)
          state_next = ST_SLEEP;
      end
      ST_DISPLAY: begin
        if (power_present)
          state_next = ST_MISSION;
        else if (wake_event)
          state_next = ST_BROWNOUT;
      end
      ST_SLEEP: begin
        // exit only on power or wake
        if (power_present)
          state_next = ST_MISSION;
        else if (wake_event)
          state_next = ST_BROWNOUT;
      end
      default: state_next = ST_MISSION;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_reg <= ST_MISSION;
      code_reg <= `CODE_POWER_GOOD;
      fail_cnt_reg <= 3'h0;
      hold_reg <= 1'b0;
      bad_seen_reg <= 1'b0;
      rewake_reg <= 1'b0;
      blink_cnt_reg <= 16'h0000;
      blink_phase_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      rewake_reg <= is_dormant(state_reg) && state_next != state_reg;
      if (code_next != `CODE_BATT_CORE_FAIL || state_reg != ST_BROWNOUT ||
          sleep_set_in)
        fail_cnt_reg <= 3'h0;
      else if (tick_rise && !fail_reset)
        fail_cnt_reg <= fail_cnt_reg + 3'h1;
      // hold reset until core supply recovers
      if (power_present || core_min)
        hold_reg <= 1'b0;
      else if (fail_reset ||
               (is_dormant(state_reg) && state_next == ST_BROWNOUT))
        hold_reg <= 1'b1;
      if (hold_reg)
        bad_seen_reg <= 1'b1;
      else if (!hold_reg && wake_out)
        bad_seen_reg <= 1'b0;
      if (state_reg != ST_DISPLAY) begin
        blink_cnt_reg <= 16'h0000;
        blink_phase_reg <= 1'b0;
      end else if (tick_rise) begin
        if (blink_cnt_reg == `BLINK_HALF_TICKS - 16'h0001) begin
          blink_cnt_reg <= 16'h0000;
          blink_phase_reg <= ~blink_phase_reg;
        end else begin
          blink_cnt_reg <= blink_cnt_reg + 16'h0001;
        end
      end
    end
  end

  wire in_display = state_next == ST_DISPLAY;
  wire asleep     = is_dormant(state_next);
  wire wake_now   = !asleep && !hold_reg;

  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      sfr_rdata_out <= 8'h00;
    end else begin
      if (sfr_rd_in && sfr_addr_in == `SUPPLY_STATE_ADDR)
        sfr_rdata_out <= {5'h00, code_reg};
      else
        sfr_rdata_out <= 8'h00;
    end
  end

  // Mode, supply source and supply-driven blocking
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      mode_out <= ST_MISSION;
      on_battery_out <= 1'b0;
      battery_irq_out <= 1'b0;
      converter_clock_enable_out <= 1'b1;
      flash_write_block_out <= 1'b0;
    end else begin
      mode_out <= state_next;
      on_battery_out <= !power_present;
      battery_irq_out <= on_battery_out == 1'b0 && !power_present;
      converter_clock_enable_out <= power_present;
      flash_write_block_out <= code_reg == `CODE_BATT_CORE_MARGIN;
    end
  end

  // Clock and rail gating per mode
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      pll_enable_out <= 1'b1;
      digital_supply_rail_out <= 1'b1;
      segment_drive_out <= 1'b0;
    end else begin
      if (in_display)
        pll_enable_out <= display_boost_select_in == `BOOST_SELECT_ON;
      else
        pll_enable_out <= state_next != ST_SLEEP;
      digital_supply_rail_out <= !asleep;
      segment_drive_out <= segment_drive_in && state_next != ST_SLEEP;
    end
  end

  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      blink_segment_pin_a_out <= 1'b0;
      blink_segment_pin_b_out <= 1'b0;
    end else begin
      blink_segment_pin_a_out <= blink_level(segment_a_data_in,
                                             blink_enable_a_in,
                                             in_display, blink_phase_reg);
      blink_segment_pin_b_out <= blink_level(segment_b_data_in,
                                             blink_enable_b_in,
                                             in_display, blink_phase_reg);
    end
  end

  // Processor reset and wake
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      processor_reset_out <= 1'b0;
      wake_out <= 1'b1;
      config_reset_out <= 1'b0;
    end else begin
      processor_reset_out <= !wake_now || fail_reset;
      wake_out <= wake_now && !fail_reset;
      // restart and config reset after dormancy
      config_reset_out <= rewake_reg;
    end
  end

  // flag on recovery, cleared when wake falls except through fail_reset
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      low_core_supply_wake_flag_out <= 1'b0;
    end else begin
      if (bad_seen_reg && !hold_reg && wake_now)
        low_core_supply_wake_flag_out <= 1'b1;
      else if (wake_out && !wake_now)
        low_core_supply_wake_flag_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: dv/supply_model.sv
// Purpose: Supply comparators and slow tick facing the sequencer.
// Assumes: Level 0 good, 1 low, 2 battery, 3 marginal, 4 failing.
// Notes: Tick period is 32 clocks to keep runs short.
`timescale 1ns/1ps
`default_nettype none
module supply_model (
  input  wire logic       sys_clk_in,
  input  wire logic [2:0] level_in,
  output wire logic       hi_out,
  output wire logic       lo_out,
  output wire logic       mid_out,
  output wire logic       min_out,
  output wire logic       tick_out
);
  logic [4:0] cnt = 5'h0;
  assign hi_out = level_in == 3'h0;
  assign lo_out = level_in < 3'h2;
  assign mid_out = level_in < 3'h3;
  assign min_out = level_in < 3'h4;
  assign tick_out = cnt[4];
  always @(negedge sys_clk_in) cnt <= cnt + 5'h1;
endmodule
`default_nettype wire

// File: dv/power_seq_checker.sv
// Purpose: Port checks for the battery mode power sequencer.
// Assumes: Supply pin history stands in for the synchroniser.
// Notes: Bound to every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module power_seq_checker (
  input wire       sys_clk_in,
  input wire       reset_in,
  input wire       sys_above_lo_in,
  input wire       sleep_set_in,
  input wire       display_only_request_in,
  input wire [1:0] display_boost_select_in,
  input wire [7:0] sfr_addr_in,
  input wire       sfr_rd_in,
  input wire [7:0] sfr_rdata_out,
  input wire [3:0] mode_out,
  input wire       on_battery_out,
  input wire       battery_irq_out,
  input wire       pll_enable_out,
  input wire       processor_reset_out,
  input wire       flash_write_block_out,
  input wire       converter_clock_enable_out
);
  reg  [2:0] lo_hist;
  wire       gone = !sys_above_lo_in && lo_hist == 3'h0;
  wire       back = sys_above_lo_in && lo_hist[0];
  wire       rd_f9 = sfr_rd_in && sfr_addr_in == 8'hF9;
  wire       bo = mode_out == 4'h2;
  always @(posedge sys_clk_in) lo_hist <= {lo_hist[1:0], sys_above_lo_in};
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  a_mode_onehot: assert property ($onehot(mode_out))
    else $error("mode not one-hot");
  a_read_status: assert property (rd_f9 ##1 rd_f9 |=>
    sfr_rdata_out[7:3] == 5'h0 &&
    flash_write_block_out == (sfr_rdata_out[2:0] == 3'h3))
    else $error("status read wrong");
  a_irq_switch: assert property ($rose(on_battery_out) |-> ##[0:1] battery_irq_out)
    else $error("no battery interrupt");
  a_conv_stop: assert property (on_battery_out |-> !converter_clock_enable_out)
    else $error("converter clock on battery");
  a_pll_display: assert property (mode_out == 4'h4 && $past(mode_out) == 4'h4
    && $stable(display_boost_select_in) |->
    pll_enable_out == (display_boost_select_in == 2'h2))
    else $error("display pll wrong");
  a_pll_brownout: assert property ($past(mode_out) == 4'h1 && bo |-> pll_enable_out)
    else $error("pll dropped");
  a_sleep_entry: assert property (bo && sleep_set_in && gone
    && !display_only_request_in |=> mode_out == 4'h8)
    else $error("sleep not entered");
  a_power_back: assert property (bo && back && !sleep_set_in
    && !display_only_request_in |-> ##[1:3] mode_out == 4'h1)
    else $error("no return to mission");
  c_display: cover property (mode_out == 4'h4);
  c_sleep: cover property (mode_out == 4'h8);
  c_fail: cover property ($rose(processor_reset_out));
endmodule
bind battery_mode_power_sequencer power_seq_checker u_power_seq_checker (
  .sys_clk_in, .reset_in, .sys_above_lo_in, .sleep_set_in,
  .display_only_request_in, .display_boost_select_in, .sfr_addr_in,
  .sfr_rd_in, .sfr_rdata_out, .mode_out, .on_battery_out, .battery_irq_out,
  .pll_enable_out, .processor_reset_out, .flash_write_block_out,
  .converter_clock_enable_out);
`default_nettype wire

// File: dv/battery_mode_power_sequencer_tb.sv
// Purpose: Self-checking bench for the battery mode power sequencer.
// Assumes: Supply model drives comparators and slow tick.
// Notes: Expected codes come from a level table.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin \
  mismatches++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module battery_mode_power_sequencer_tb;
  logic sys_clk_in = 0, reset_in = 1, sleep_set_in = 0, sfr_rd_in = 0;
  logic display_only_request_in = 0, segment_drive_in = 0;
  logic blink_enable_a_in = 0, blink_enable_b_in = 0;
  logic segment_a_data_in = 0, segment_b_data_in = 0;
  logic [1:0] display_boost_select_in = 0;
  logic [7:0] sfr_addr_in = 0, sfr_rdata_out, d;
  logic [3:0] mode_out, wk = 0;
  logic [2:0] level = 0;
  logic [31:0] seed = 32'h6;
  wire sys_above_hi_in, sys_above_lo_in, core_above_mid_in, core_above_min_in;
  wire slow_tick_clock_in, wake_timer_in, pushbutton_in, seg_wake_in;
  wire serial_rx_in;
  logic on_battery_out, battery_irq_out, pll_enable_out, wake_out;
  logic digital_supply_rail_out, segment_drive_out, config_reset_out;
  logic blink_segment_pin_a_out, blink_segment_pin_b_out;
  logic processor_reset_out, flash_write_block_out;
  logic converter_clock_enable_out, low_core_supply_wake_flag_out;
  int mismatches = 0, n_compared = 0, irq_n = 0, cfg_n = 0, wf_n = 0, c;
  int code_of[5] = '{0, 1, 2, 3, 5};
  assign {wake_timer_in, pushbutton_in, seg_wake_in, serial_rx_in} = wk;
  battery_mode_power_sequencer u_battery_mode_power_sequencer (.*);
  supply_model u_supply_model (.sys_clk_in, .level_in(level),
    .hi_out(sys_above_hi_in), .lo_out(sys_above_lo_in),
    .mid_out(core_above_mid_in), .min_out(core_above_min_in),
    .tick_out(slow_tick_clock_in));
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    irq_n += battery_irq_out;
    cfg_n += config_reset_out;
    wf_n += $fell(wake_out);
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic rnd();
    seed = xs(seed);
    {blink_enable_a_in, blink_enable_b_in, segment_a_data_in,
     segment_b_data_in, segment_drive_in} = seed[4:0];
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr_in = a;
    sfr_rd_in = 1;
    cyc(2);
    d = sfr_rdata_out;
    sfr_rd_in = 0;
  endtask
  task automatic sleep_mode();
    sleep_set_in = 1;
    cyc(1);
    sleep_set_in = 0;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    cyc(20);
    reset_in = 0;
    cyc(2);
    `CHK("mode", 4'h1, mode_out)
    for (int i = 0; i < 4; i++) begin
      level = i;
      cyc(8);
      rd(8'hF9);
      `CHK("code", code_of[i], d)
      `CHK("flash", code_of[i] == 3, flash_write_block_out)
      `CHK("battery", i > 1, on_battery_out)
      `CHK("conv", i < 2, converter_clock_enable_out)
      `CHK("mode", i > 1 ? 2 : 1, mode_out)
    end
    rd(8'hF8);
    `CHK("unmapped", 0, d)
    `CHK("irq", 1, irq_n)
    `CHK("pll", 1, pll_enable_out)
    $display("levels done");
    for (int i = 0; i < 4; i++) begin
      rnd();
      sleep_mode();
      cyc(20);
      `CHK("sleep", 4'h8, mode_out)
      wk[i] = 1;
      cyc(2);
      wk[i] = 0;
      cyc(8);
      `CHK("wake", 4'h2, mode_out)
    end
    $display("wake done");
    for (int b = 0; b < 2; b++) begin
      rnd();
      display_boost_select_in = b ? 2'h2 : seed[9:8];
      display_only_request_in = 1;
      cyc(3);
      display_only_request_in = 0;
      cyc(2);
      `CHK("display", 4'h4, mode_out)
      `CHK("pll", display_boost_select_in == 2'h2, pll_enable_out)
      `CHK("rail", 0, digital_supply_rail_out)
      `CHK("segdrive", segment_drive_in, segment_drive_out)
      `CHK("blink_a", segment_a_data_in, blink_segment_pin_a_out)
      `CHK("blink_b", segment_b_data_in, blink_segment_pin_b_out)
      c = cfg_n;
      wk[2] = 1;
      cyc(2);
      wk[2] = 0;
      cyc(8);
      `CHK("leave", 4'h2, mode_out)
      `CHK("restart", c + 1, cfg_n)
    end
    $display("display done");
    sleep_mode();
    cyc(2);
    level = 0;
    cyc(8);
    `CHK("power", 4'h1, mode_out)
    level = 2;
    cyc(8);
    @(posedge slow_tick_clock_in);
    cyc(1);
    level = 4;
    cyc(8);
    rd(8'hF9);
    `CHK("code", 5, d)
    repeat (3) @(posedge slow_tick_clock_in);
    cyc(2);
    `CHK("early", 0, processor_reset_out)
    @(posedge slow_tick_clock_in);
    cyc(6);
    `CHK("hold", 2'b10, {processor_reset_out, wake_out})
    level = 3;
    cyc(40);
    `CHK("recover", 2'b01, {processor_reset_out, wake_out})
    `CHK("flag", 1, low_core_supply_wake_flag_out)
    level = 0;
    cyc(8);
    `CHK("return", 4'h1, mode_out)
    $display("core fail done");
    c = wf_n;
    sleep_mode();
    cyc(10);
    `CHK("rewake", 4'h1, mode_out)
    `CHK("wakefall", c + 1, wf_n)
    `CHK("flagclr", 0, low_core_supply_wake_flag_out)
    $display("rewake done");
    give_verdict();
  end
  initial begin
    #400us;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
